// ### verilog/rtc_pkg.sv
// Shared constants, register map and carrier types of the time-latch and interrupt block.
package rtc_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int NUM_CNT = 8;
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int NUM_INC = 6;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] ADDR_HUND        = 5'h00;
  localparam logic [4:0] ADDR_TIME_LAST   = 5'h07;
  localparam logic [4:0] ADDR_ALARM_FIRST = 5'h08;
  localparam logic [4:0] ADDR_ALARM_LAST  = 5'h0F;
  localparam logic [4:0] ADDR_FLAGS       = 5'h10;
  localparam logic [4:0] ADDR_CMD         = 5'h11;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int IDX_HUND       = 0;
  localparam int FLAG_ALARM     = 0;
  localparam int FLAG_ANY       = 7;
  localparam int SEL_FIRST      = 1;
  localparam int SEL_LAST       = 6;
  localparam int ALARM_MASK_BIT = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam logic [7:0] CMD_RESET   = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef logic [7:0] byte_t;
  typedef byte_t [NUM_CNT-1:0] bank_t;

  typedef struct packed {
    logic       ale;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [4:0] addr;
    logic [7:0] data;
  } bus_pins_t;

  typedef struct packed {
    logic [1:0] spare;
    logic       test;
    logic       gie;
    logic       run;
    logic       fmt24;
    logic [1:0] freq;
  } cmd_t;

  typedef struct packed {
    logic       stb;
    logic [2:0] idx;
    logic [7:0] data;
  } counter_set_t;

  localparam bus_pins_t IDLE_PINS = '{ale: 1'b1, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                      addr: 5'h00, data: 8'h00};

endpackage

// ### verilog/alarm_match.sv
// Alarm comparator with per-field masking.
`timescale 1ns/10ps
`default_nettype none

module alarm_match
  import rtc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire bank_t time_now,
  input  wire bank_t alarm,
  output logic       match
);

  logic [NUM_CNT-1:0] field_ok;
  logic [NUM_CNT-1:0] mask_bits;

  // ****************************************************************
  // Field compare
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_field
      assign mask_bits[g] = alarm[g][ALARM_MASK_BIT];
      if (g == IDX_HUND) begin : g_hund
        // A masked hundredths field compares against zero, not against anything.
        assign field_ok[g] = alarm[g][ALARM_MASK_BIT] ? (time_now[g][6:0] == 7'h00) :
                             (time_now[g][6:0] == alarm[g][6:0]);
      end else begin : g_other
        assign field_ok[g] = alarm[g][ALARM_MASK_BIT] |
                             (time_now[g][6:0] == alarm[g][6:0]);
      end
    end
  endgenerate

  assign match = &field_ok;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_hund_as_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm[IDX_HUND][ALARM_MASK_BIT] && match) |-> (time_now[IDX_HUND][6:0] == 7'h00))
    else $error("masked hundredths alarm matched a nonzero count");

  a_masked_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    ((&mask_bits) && (time_now[IDX_HUND][6:0] == 7'h00)) |-> match)
    else $error("masked alarm field still blocked the match");

endmodule

`default_nettype wire

// ### verilog/rtc_latch_irq.sv
// Bus slave, time snapshot latches, status flags and interrupt logic of the clock.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Reading hundredths copies the seven higher counters into latches; host reads it first.
// - Hundredths read data comes live from the counter, never from a latch.
// - Latched values hold until the next hundredths read.
// - Alarm locations read back their stored contents, untouched by snapshots.
// - Invalid backup supply blocks all bus reads and writes; timekeeping goes on.
// - Status flags every counter increment since the last read, regardless of masks.
// - Each status read clears all status bits after the data is delivered.
// - Status top bit is set when an interrupt was raised since the last read.
// - An alarm-caused interrupt also sets status bit zero.
// - A status read releases the interrupt output transistor.
// - Periodic interrupt needs global enable and at least one periodic select bit.
// - Periodic interrupt fires on each increment of a selected counter.
// - Alarm interrupt needs global enable and the alarm enable bit.
// - With both enables set, each alarm match sets status bits zero and seven and turns the transistor on.
// - Masked alarm fields above hundredths are left out of the comparison.
// - A masked hundredths alarm field behaves as if programmed to zero.
// - Writing 10H loads the mask; 00H disables all; reading 10H returns status.
// - Location 11H holds frequency select, global enable, run/stop and test bits.
// - Mask value 08H enables only the one-second periodic interrupt.
module rtc_latch_irq
  import rtc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire bus_pins_t          bus_in,
  input  wire logic               backup_supply_pin,
  input  wire bank_t              time_now,
  input  wire logic [NUM_INC-1:0] counter_inc,
  output logic [DATA_W-1:0]       data_out,
  output logic                    data_oe,
  output logic                    irq_out,
  output logic                    irq_oe,
  output counter_set_t            counter_set,
  output cmd_t                    command
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    bus_pins_t    s1;
    bus_pins_t    s2;
    logic         bk1;
    logic         bk2;
    logic [4:0]   addr_q;
    logic         cs_q;
    logic         rd_prev;
    logic         wr_prev;
    logic [4:0]   rd_addr;
    logic [4:0]   wr_addr;
    byte_t        wdata;
    bank_t        latch;
    bank_t        alarm;
    byte_t        mask;
    cmd_t         cmd;
    byte_t        flags;
    logic         irq_on;
    logic         match_q;
    byte_t        dout;
    logic         doe;
    counter_set_t set;
  } state_t;

  state_t     s;
  state_t     next_s;
  logic [1:0] rst_q;
  logic       rst_sync;
  logic       match;

  logic       io_ok;
  logic       cur_cs;
  logic [4:0] cur_addr;
  logic       rd_lvl;
  logic       wr_lvl;
  logic       rd_start;
  logic       rd_end;
  logic       wr_end;
  logic       flags_clr;
  logic       alarm_hit;
  logic       periodic_fire;
  logic       alarm_fire;
  logic       any_fire;

  // ****************************************************************
  // Read decode
  // ****************************************************************
  function automatic byte_t read_mux(input logic [4:0] a, input bank_t now, input bank_t lat,
                                     input bank_t alm, input byte_t flg, input cmd_t c);
    byte_t r;
    r = BYTE_ZERO;
    if (a == ADDR_HUND) begin
      r = now[IDX_HUND];
    end else if (a <= ADDR_TIME_LAST) begin
      r = lat[a[2:0]];
    end else if (a <= ADDR_ALARM_LAST) begin
      r = alm[a[2:0]];
    end else if (a == ADDR_FLAGS) begin
      r = flg;
    end else if (a == ADDR_CMD) begin
      r = c;
    end
    return r;
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_sync = rst_q[1];

  // ****************************************************************
  // Alarm comparator
  // ****************************************************************
  alarm_match u_alarm (
    .clk      (clk),
    .rst_n    (rst_sync),
    .time_now (time_now),
    .alarm    (s.alarm),
    .match    (match)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.s1 = bus_in;
    next_s.s2 = s.s1;
    next_s.bk1 = backup_supply_pin;
    next_s.bk2 = s.bk1;
    next_s.set.stb = 1'b0;

    // With ALE tied high the address latch is transparent.
    io_ok = s.bk2;
    cur_cs = s.s2.ale ? !s.s2.cs_n : s.cs_q;
    cur_addr = s.s2.ale ? s.s2.addr : s.addr_q;
    if (s.s2.ale) begin
      next_s.addr_q = s.s2.addr;
      next_s.cs_q = !s.s2.cs_n;
    end

    rd_lvl = cur_cs && !s.s2.rd_n && io_ok;
    wr_lvl = cur_cs && !s.s2.wr_n && io_ok;
    rd_start = rd_lvl && !s.rd_prev;
    rd_end = s.rd_prev && !rd_lvl && io_ok;
    wr_end = s.wr_prev && !wr_lvl && io_ok;
    next_s.rd_prev = rd_lvl;
    next_s.wr_prev = wr_lvl;
    next_s.doe = rd_lvl;

    // Read path: address is frozen at the start so a wandering bus cannot move it.
    if (rd_start) begin
      next_s.rd_addr = cur_addr;
    end
    if (rd_lvl) begin
      next_s.dout = read_mux(rd_start ? cur_addr : s.rd_addr, time_now, s.latch,
                             s.alarm, s.flags, s.cmd);
    end
    if (rd_start && cur_addr == ADDR_HUND) begin
      for (int i = 1; i < NUM_CNT; i++) begin
        next_s.latch[i] = time_now[i];
      end
    end

    // Write path: data is taken at the trailing edge of the strobe.
    if (wr_lvl) begin
      next_s.wr_addr = cur_addr;
      next_s.wdata = s.s2.data;
    end
    if (wr_end) begin
      if (s.wr_addr <= ADDR_TIME_LAST) begin
        next_s.set.stb = 1'b1;
        next_s.set.idx = s.wr_addr[2:0];
        next_s.set.data = s.wdata;
      end else if (s.wr_addr <= ADDR_ALARM_LAST) begin
        next_s.alarm[s.wr_addr[2:0]] = s.wdata;
      end else if (s.wr_addr == ADDR_FLAGS) begin
        next_s.mask = s.wdata;
      end else if (s.wr_addr == ADDR_CMD) begin
        next_s.cmd = cmd_t'(s.wdata);
      end
    end

    // Events and interrupt.
    flags_clr = rd_end && (s.rd_addr == ADDR_FLAGS);
    alarm_hit = match && !s.match_q;
    next_s.match_q = match;
    periodic_fire = s.cmd.gie && |(s.mask[SEL_LAST:SEL_FIRST] & counter_inc);
    alarm_fire = s.cmd.gie && s.mask[FLAG_ALARM] && alarm_hit;
    any_fire = periodic_fire || alarm_fire;

    // The clear is applied first so an event in the same cycle still sets its bit.
    next_s.flags = flags_clr ? FLAGS_RESET : s.flags;
    next_s.flags[SEL_LAST:SEL_FIRST] = next_s.flags[SEL_LAST:SEL_FIRST] | counter_inc;
    next_s.flags[FLAG_ALARM] = next_s.flags[FLAG_ALARM] | alarm_fire;
    next_s.flags[FLAG_ANY] = next_s.flags[FLAG_ANY] | any_fire;
    next_s.irq_on = (flags_clr ? 1'b0 : s.irq_on) | any_fire;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      s <= '0;
      s.s1 <= IDLE_PINS;
      s.s2 <= IDLE_PINS;
      s.rd_addr <= ADDR_HUND;
      s.mask <= MASK_RESET;
      s.cmd <= cmd_t'(CMD_RESET);
      s.flags <= FLAGS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign data_out = s.dout;
  assign data_oe = s.doe;
  // Open drain: the pad only ever pulls low.
  assign irq_out = 1'b0;
  assign irq_oe = s.irq_on;
  assign counter_set = s.set;
  assign command = s.cmd;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_snapshot_copy: assert property (@(posedge clk) disable iff (!rst_sync)
    (rd_start && cur_addr == ADDR_HUND) |=> (s.latch[1] == $past(time_now[1])) &&
                                           (s.latch[7] == $past(time_now[7])))
    else $error("hundredths read did not snapshot the higher counters");

  a_hund_live: assert property (@(posedge clk) disable iff (!rst_sync)
    (rd_lvl && !rd_start && s.rd_addr == ADDR_HUND) |=> s.dout == $past(time_now[IDX_HUND]))
    else $error("hundredths read data is not live");

  a_latch_stable: assert property (@(posedge clk) disable iff (!rst_sync)
    !(rd_start && cur_addr == ADDR_HUND) |=> $stable(s.latch))
    else $error("latched time changed without a hundredths read");

  a_alarm_direct: assert property (@(posedge clk) disable iff (!rst_sync)
    (rd_lvl && !rd_start && s.rd_addr == ADDR_ALARM_FIRST) |=> s.dout == $past(s.alarm[0]))
    else $error("alarm location did not read its stored value");

  a_io_blocked: assert property (@(posedge clk) disable iff (!rst_sync)
    !s.bk2 |=> !s.doe && !s.set.stb && $stable(s.mask) && $stable(s.alarm))
    else $error("bus access took effect with backup supply invalid");

  a_inc_flagged: assert property (@(posedge clk) disable iff (!rst_sync)
    counter_inc[2] |=> s.flags[3])
    else $error("seconds increment not flagged in status");

  a_status_clear: assert property (@(posedge clk) disable iff (!rst_sync)
    (flags_clr && counter_inc == 6'h00 && !alarm_fire) |=> s.flags == FLAGS_RESET)
    else $error("status not cleared after its read");

  a_irq_summary: assert property (@(posedge clk) disable iff (!rst_sync)
    s.irq_on |-> s.flags[FLAG_ANY])
    else $error("interrupt on without summary flag");

  a_alarm_irq: assert property (@(posedge clk) disable iff (!rst_sync)
    alarm_fire |=> s.flags[FLAG_ALARM] && s.flags[FLAG_ANY] && s.irq_on)
    else $error("alarm match did not set flags and interrupt");

  a_irq_release: assert property (@(posedge clk) disable iff (!rst_sync)
    (flags_clr && !any_fire) |=> !irq_oe)
    else $error("status read did not release the interrupt");

  a_irq_gated: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(s.irq_on) |-> $past(s.cmd.gie) && ($past(s.mask) != MASK_RESET))
    else $error("interrupt raised while its sources were disabled");

  a_second_fire: assert property (@(posedge clk) disable iff (!rst_sync)
    (s.cmd.gie && s.mask[3] && counter_inc[2]) |=> s.irq_on ##0 s.flags[FLAG_ANY])
    else $error("selected counter increment did not interrupt");

  a_mask_write: assert property (@(posedge clk) disable iff (!rst_sync)
    (wr_end && s.wr_addr == ADDR_FLAGS) |=> s.mask == $past(s.wdata))
    else $error("write to 10H did not load the mask");

endmodule

`default_nettype wire

// ### bench/host_model.sv
// Behavioural model of the microprocessor that reads and writes the clock.
`timescale 1ns/10ps
`default_nettype none

module host_model
  import rtc_pkg::*;
(
  input  wire logic       clk,
  output var  bus_pins_t  pins,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            rd_done,
  output logic [7:0]      rd_data
);
  initial begin
    pins    = IDLE_PINS;
    rd_done = 1'b0;
    rd_data = 8'h00;
  end

  // The caller reads hundredths before the higher counters.
  // The strobe is held until data_oe is sampled high at an edge; data is taken at that edge.
  // A blocked device gives up after 8 cycles.
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk);
    #1;
    pins.cs_n = 1'b0;
    pins.rd_n = 1'b0;
    pins.addr = a;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge clk);
      if (data_oe === 1'b1) begin
        ok = 1'b1;
        d  = data_out;
      end
    end
    #1;
    pins.cs_n = 1'b1;
    pins.rd_n = 1'b1;
    pins.data = ~pins.data;
    repeat (4) @(posedge clk);
    #1;
    if (ok) begin
      rd_data = d;
      rd_done = 1'b1;
      @(posedge clk);
      #1;
      rd_done = 1'b0;
    end
  endtask

  // Address and data stay put well past the strobe, since the device samples late.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    pins.cs_n = 1'b0;
    pins.wr_n = 1'b0;
    pins.addr = a;
    pins.data = d;
    repeat (3) @(posedge clk);
    #1;
    pins.cs_n = 1'b1;
    pins.wr_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    pins.data = ~d;
  endtask

  // Multiplexed bus: address and select are caught while ale is high and kept once it falls.
  task automatic set_ale(input logic [4:0] a, input logic level);
    @(posedge clk);
    #1;
    pins.ale  = 1'b1;
    pins.cs_n = 1'b0;
    pins.addr = a;
    repeat (3) @(posedge clk);
    #1;
    pins.ale  = level;
    pins.cs_n = 1'b1;
    pins.addr = ~a;
    repeat (2) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// ### bench/rtc_latch_irq_bench.sv
// Self-checking bench of the time-latch and interrupt block.
`timescale 1ns/10ps
`default_nettype none

module rtc_latch_irq_bench
  import rtc_pkg::*;
  ;
  logic               clk;
  logic               rstn;
  logic               backup;
  bus_pins_t          pins;
  bank_t              tnow;
  bank_t              held;
  logic [NUM_INC-1:0] inc;
  logic [7:0]         dout;
  logic               doe;
  logic               irq_oe;
  logic               irq_pin;
  counter_set_t       cset;
  counter_set_t       cset_seen;
  int                 n_stb = 0;
  cmd_t               cmd;
  logic               rd_done;
  logic [7:0]         rd_data;
  logic [7:0]         exp_q[$];
  integer             seed;
  integer             fails;
  integer             n_checks;

  rtc_latch_irq dut (
    .clk               (clk),
    .rstn              (rstn),
    .bus_in            (pins),
    .backup_supply_pin (backup),
    .time_now          (tnow),
    .counter_inc       (inc),
    .data_out          (dout),
    .data_oe           (doe),
    .irq_out           (irq_pin),
    .irq_oe            (irq_oe),
    .counter_set       (cset),
    .command           (cmd)
  );

  host_model host (
    .clk      (clk),
    .pins     (pins),
    .data_out (dout),
    .data_oe  (doe),
    .rd_done  (rd_done),
    .rd_data  (rd_data)
  );

  // ****************************************************************
  // Clock, checking and closing
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rd_exp(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    exp_q.push_back(e);
    host.rd(a, d, ok);
    check(16'(ok), 16'h0001);
    if (ok !== 1'b1) begin
      void'(exp_q.pop_back());
    end
  endtask

  // The last forwarded counter write is kept, with a count of all strobes.
  always @(posedge clk) begin
    if (cset.stb === 1'b1) begin
      cset_seen <= cset;
      n_stb     <= n_stb + 1;
    end
  end

  // Every completed read is matched against the oldest note.
  always @(posedge clk) begin
    if (rd_done === 1'b1) begin
      check(16'(rd_data), 16'(exp_q.pop_front()));
    end
  end

  // The run needs well under 3000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    int         k;
    int         g;
    logic [31:0] r;
    logic [7:0] e;
    logic       ok;
    seed     = 32'h4B92055C;
    fails    = 0;
    n_checks = 0;
    rstn     = 1'b0;
    backup   = 1'b1;
    inc      = '0;
    for (k = 0; k < NUM_CNT; k++) begin
      r = $random(seed);
      tnow[k] = {1'b0, r[6:0]};
    end
    tnow[IDX_HUND] = 8'h05;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (6) @(posedge clk);
    rd_exp(ADDR_FLAGS, FLAGS_RESET);
    $display("Test reset done");

    // Counters move between the snapshot and the reads of the held values.
    for (g = 0; g < 2; g++) begin
      tnow[IDX_HUND] = 8'h05 + 8'(g);
      rd_exp(ADDR_HUND, tnow[IDX_HUND]);
      held = tnow;
      for (k = 1; k < NUM_CNT; k++) begin
        r = $random(seed);
        tnow[k] = {1'b0, r[6:0]};
      end
      for (k = 1; k < NUM_CNT; k++) rd_exp(5'(k), held[k]);
    end
    $display("Test snapshot done");

    for (k = 8; k < 16; k++) host.wr(5'(k), 8'h80);
    for (k = 8; k < 16; k++) rd_exp(5'(k), 8'h80);
    rd_exp(5'h15, BYTE_ZERO);
    host.set_ale(ADDR_ALARM_FIRST, 1'b0);
    rd_exp(5'h15, 8'h80);
    host.set_ale(ADDR_HUND, 1'b1);
    $display("Test alarm storage done");

    // Each counter in turn; only seconds is selected, first with the global enable off.
    host.wr(ADDR_FLAGS, 8'h08);
    for (g = 0; g < 2; g++) begin
      host.wr(ADDR_CMD, (g == 1) ? 8'h10 : 8'h00);
      check(16'(cmd), (g == 1) ? 16'h0010 : 16'h0000);
      for (k = 0; k < NUM_INC; k++) begin
        @(posedge clk);
        #1 inc[k] = 1'b1;
        @(posedge clk);
        #1 inc[k] = 1'b0;
        repeat (3) @(posedge clk);
        check(16'(irq_oe), 16'(g == 1 && k == 2));
        e = (8'h01 << (k + 1)) | ((g == 1 && k == 2) ? 8'h80 : 8'h00);
        rd_exp(ADDR_FLAGS, e);
        check(16'(irq_oe), 16'h0000);
      end
    end
    $display("Test periodic done");

    // Every alarm field masked: only a zero hundredths count can match.
    host.wr(ADDR_FLAGS, 8'h01);
    rd_exp(ADDR_FLAGS, 8'h00);
    check(16'(irq_oe), 16'h0000);
    @(posedge clk);
    #1 tnow[IDX_HUND] = 8'h00;
    repeat (4) @(posedge clk);
    check(16'(irq_oe), 16'h0001);
    check(16'(irq_pin), 16'h0000);
    // A tenths increment lands in the very cycle in which this read clears the status.
    fork
      rd_exp(ADDR_FLAGS, 8'h81);
      begin
        repeat (7) @(posedge clk);
        #1 inc[1] = 1'b1;
        @(posedge clk);
        #1 inc[1] = 1'b0;
      end
    join
    check(16'(irq_oe), 16'h0000);
    rd_exp(ADDR_FLAGS, 8'h04);
    $display("Test alarm done");

    host.wr(5'h03, 8'h2A);
    check(16'({cset_seen.idx, cset_seen.data}), 16'h032A);
    check(16'(n_stb), 16'h0001);

    @(posedge clk);
    #1 backup = 1'b0;
    repeat (4) @(posedge clk);
    host.wr(ADDR_CMD, 8'h00);
    host.wr(5'h03, 8'h55);
    check(16'(n_stb), 16'h0001);
    host.rd(ADDR_CMD, e, ok);
    check(16'(ok), 16'h0000);
    check(16'(cmd), 16'h0010);
    @(posedge clk);
    #1 backup = 1'b1;
    repeat (4) @(posedge clk);
    rd_exp(ADDR_HUND, 8'h00);
    $display("Test backup done");
    report_and_stop();
  end
endmodule

`default_nettype wire
